// [design/ldi_consts.svh]
`ifndef LDI_CONSTS_SVH
`define LDI_CONSTS_SVH
`define LDI_BUS_W 16
`define LDI_BYTE_W 8
`define LDI_FIFO_DEPTH 32
`define LDI_FIFO_AW 5
`endif

// [design/ldi_pkg.sv]
package ldi_pkg;
    typedef struct packed {
        logic [15:0] data;
        logic frame_rise;
        logic frame_fall;
    } ldi_word_t;
    typedef enum logic [1:0] {
        LDI_LOW = 2'b00,
        LDI_BYTE_HI = 2'b01
    } ldi_asm_t;
endpackage : ldi_pkg

// [design/ldi_fifo.sv]
`timescale 1ns/1ps
`include "ldi_consts.svh"
module ldi_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [AW:0] next_wp;
    logic [AW:0] next_rp;
    logic do_wr;
    logic do_rd;
    logic full;
    logic empty;
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty = (wp == rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp[AW-1:0]];
    assign do_wr = in_valid && !full;
    assign do_rd = out_ready && !empty;
    always_comb begin
        next_wp = wp;
        next_rp = rp;
        if (flush) begin
            next_wp = '0;
            next_rp = '0;
        end else begin
            if (do_wr) next_wp = wp + 1'b1;
            if (do_rd) next_rp = rp + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
        if (do_wr && !flush) mem[wp[AW-1:0]] <= in_data;
    end
endmodule : ldi_fifo

// [design/ldi_port.sv]
`timescale 1ns/1ps
`include "ldi_consts.svh"
module ldi_port
    import ldi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic forwarded_sample_clock,
    input wire logic [15:0] data_lines,
    input wire logic frame_indicator,
    input wire logic byte_mode,
    input wire logic bus_reverse,
    input wire logic frame_resets_fifo,
    input wire logic ext_ref_select,
    input wire logic internal_ref_level,
    input wire logic reference_pin_in,
    output logic reference_pin_out,
    output logic reference_pin_oe,
    output logic ext_ref_sample,
    output logic sync_pulse,
    output logic sample_valid,
    input wire logic sample_ready,
    output logic [15:0] sample_data,
    output logic sample_parity,
    output logic overflow
);
    // Two-flop sync of the link, config and reference pins; the link clock is oversampled, not used as a clock
    logic [17:0] meta;
    logic [17:0] sync;
    logic [17:0] next_sync;
    logic clk_prev;
    logic [2:0] cfg_meta;
    logic [2:0] cfg;
    logic [1:0] ref_meta;
    logic [1:0] ref_sync;
    always_comb next_sync = meta;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            sync <= '0;
            clk_prev <= 1'b0;
            cfg_meta <= '0;
            cfg <= '0;
            ref_meta <= '0;
            ref_sync <= '0;
        end else begin
            meta <= {forwarded_sample_clock, frame_indicator, data_lines};
            sync <= next_sync;
            clk_prev <= sync[17];
            cfg_meta <= {byte_mode, bus_reverse, frame_resets_fifo};
            cfg <= cfg_meta;
            ref_meta <= {ext_ref_select, reference_pin_in};
            ref_sync <= ref_meta;
        end
    end

    // Edge detector resets low, matching the idle link clock level
    logic rise;
    logic fall;
    logic edge_any;
    logic [15:0] ordered;
    assign rise = sync[17] && !clk_prev;
    assign fall = !sync[17] && clk_prev;
    assign edge_any = rise || fall;

    // Bus reversal mirrors the whole sixteen-line bus, before width selection
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_rev
            assign ordered[gi] = cfg[1] ? sync[15-gi] : sync[gi];
        end
    endgenerate

    // Byte assembly: first byte of a pair is the high byte
    // Word mode parks the pairing state so byte mode starts on a high byte
    ldi_asm_t st;
    ldi_asm_t next_st;
    logic [7:0] hi_byte;
    logic [7:0] next_hi_byte;
    logic push;
    logic [15:0] push_data;
    logic frame_r;
    logic next_frame_r;
    logic frame_f;
    logic next_frame_f;
    always_comb begin
        next_st = st;
        next_hi_byte = hi_byte;
        next_frame_r = frame_r;
        next_frame_f = frame_f;
        push = 1'b0;
        push_data = ordered;
        if (rise) next_frame_r = sync[16];
        if (fall) next_frame_f = sync[16];
        if (edge_any) begin
            if (!cfg[2]) begin
                push = 1'b1;
                next_st = LDI_LOW;
            end else begin
                case (st)
                    LDI_LOW: begin
                        next_hi_byte = ordered[7:0];
                        next_st = LDI_BYTE_HI;
                    end
                    LDI_BYTE_HI: begin
                        push = 1'b1;
                        push_data = {hi_byte, ordered[7:0]};
                        next_st = LDI_LOW;
                    end
                    default: next_st = LDI_LOW;
                endcase
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= LDI_LOW;
            hi_byte <= '0;
            frame_r <= 1'b0;
            frame_f <= 1'b0;
        end else begin
            st <= next_st;
            hi_byte <= next_hi_byte;
            frame_r <= next_frame_r;
            frame_f <= next_frame_f;
        end
    end

    // Frame rising-edge event: flush FIFO or emit sync
    // Only a 0-to-1 step counts, so a held-high indicator fires once
    logic frame_evt;
    logic flush;
    logic next_sync_pulse;
    assign frame_evt = rise && sync[16] && !frame_r;
    assign flush = frame_evt && cfg[0];
    always_comb next_sync_pulse = frame_evt && !cfg[0];

    ldi_word_t fin;
    ldi_word_t fout;
    logic fin_ready;
    logic fout_valid;
    logic pop;
    logic next_overflow;
    assign fin.data = push_data;
    assign fin.frame_rise = sync[16];
    assign fin.frame_fall = fall ? sync[16] : frame_f;
    ldi_fifo #(
        .WIDTH($bits(ldi_word_t)),
        .DEPTH(`LDI_FIFO_DEPTH),
        .AW(`LDI_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(flush),
        .in_valid(push),
        .in_ready(fin_ready),
        .in_data(fin),
        .out_valid(fout_valid),
        .out_ready(pop),
        .out_data(fout)
    );
    // Link cannot be stalled, so a full FIFO drops the sample and flags it
    always_comb next_overflow = overflow || (push && !fin_ready && !flush);
    assign pop = fout_valid && (!sample_valid || sample_ready);

    logic next_valid;
    logic [15:0] next_data;
    logic next_parity;
    logic next_ref_out;
    logic next_ref_oe;
    logic next_ext_ref;
    // Output stage holds a word until taken; flush empties it too
    always_comb begin
        next_valid = sample_valid;
        next_data = sample_data;
        next_parity = sample_parity;
        if (sample_valid && sample_ready) next_valid = 1'b0;
        if (pop) begin
            next_valid = 1'b1;
            next_data = fout.data;
            next_parity = fout.frame_fall;
        end
        if (flush) next_valid = 1'b0;
        next_ref_oe = !ref_sync[1];
        next_ref_out = internal_ref_level;
        next_ext_ref = ref_sync[1] ? ref_sync[0] : 1'b0;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_valid <= 1'b0;
            sample_data <= '0;
            sample_parity <= 1'b0;
            overflow <= 1'b0;
            sync_pulse <= 1'b0;
            reference_pin_oe <= 1'b1;
            reference_pin_out <= 1'b0;
            ext_ref_sample <= 1'b0;
        end else begin
            sample_valid <= next_valid;
            sample_data <= next_data;
            sample_parity <= next_parity;
            overflow <= next_overflow;
            sync_pulse <= next_sync_pulse;
            reference_pin_oe <= next_ref_oe;
            reference_pin_out <= next_ref_out;
            ext_ref_sample <= next_ext_ref;
        end
    end

    property p_ddr_push;
        @(posedge clk) disable iff (rst) (edge_any && !cfg[2]) |-> push;
    endproperty
    a_ddr_push: assert property (p_ddr_push) else $error("word edge not pushed");
    property p_word_order;
        @(posedge clk) disable iff (rst) (push && !cfg[2] && !cfg[1]) |-> push_data == sync[15:0];
    endproperty
    a_word_order: assert property (p_word_order) else $error("word bit order wrong");
    property p_byte_low;
        @(posedge clk) disable iff (rst) (push && cfg[2]) |-> push_data[7:0] == ordered[7:0];
    endproperty
    a_byte_low: assert property (p_byte_low) else $error("byte lane wrong");
    property p_reverse;
        @(posedge clk) disable iff (rst) cfg[1] |-> ordered[0] == sync[15] && ordered[15] == sync[0];
    endproperty
    a_reverse: assert property (p_reverse) else $error("bus not reversed");
    property p_flush;
        @(posedge clk) disable iff (rst) flush |=> !sample_valid;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left data");
    property p_sync;
        @(posedge clk) disable iff (rst) (frame_evt && !cfg[0]) |=> sync_pulse;
    endproperty
    a_sync: assert property (p_sync) else $error("sync pulse missing");
    property p_fall_cap;
        @(posedge clk) disable iff (rst) fall |=> frame_f == $past(sync[16]);
    endproperty
    a_fall_cap: assert property (p_fall_cap) else $error("falling frame not caught");
    property p_ref;
        @(posedge clk) disable iff (rst) ref_sync[1] |=> !reference_pin_oe;
    endproperty
    a_ref: assert property (p_ref) else $error("reference pin driven in external mode");
    property p_pair;
        @(posedge clk) disable iff (rst) (cfg[2] && edge_any && st == LDI_LOW) |-> !push;
    endproperty
    a_pair: assert property (p_pair) else $error("half sample pushed");
    property p_no_stray_push;
        @(posedge clk) disable iff (rst) !edge_any |-> !push;
    endproperty
    a_no_stray_push: assert property (p_no_stray_push) else $error("push, no edge");
    property p_byte_first;
        @(posedge clk) disable iff (rst)
            (cfg[2] && edge_any && st == LDI_LOW) |=> hi_byte == $past(ordered[7:0]);
    endproperty
    a_byte_first: assert property (p_byte_first) else $error("high byte lost");
    property p_byte_second;
        @(posedge clk) disable iff (rst)
            (cfg[2] && edge_any && st == LDI_BYTE_HI) |-> push && push_data[15:8] == hi_byte;
    endproperty
    a_byte_second: assert property (p_byte_second) else $error("pair not pushed");
    property p_word_parks;
        @(posedge clk) disable iff (rst) (!cfg[2] && edge_any) |=> st == LDI_LOW;
    endproperty
    a_word_parks: assert property (p_word_parks) else $error("pairing not parked");
    property p_rise_cap;
        @(posedge clk) disable iff (rst) rise |=> frame_r == $past(sync[16]);
    endproperty
    a_rise_cap: assert property (p_rise_cap) else $error("rising frame not caught");
    property p_flush_quiet;
        @(posedge clk) disable iff (rst) flush |=> !sync_pulse;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet) else $error("sync in flush mode");
    property p_sync_cause;
        @(posedge clk) disable iff (rst) sync_pulse |-> $past(frame_evt && !cfg[0]);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("stray sync pulse");
    property p_ref_drive;
        @(posedge clk) disable iff (rst) !ref_sync[1] |=> reference_pin_oe;
    endproperty
    a_ref_drive: assert property (p_ref_drive) else $error("reference not driven");
    property p_ext_sample;
        @(posedge clk) disable iff (rst) ref_sync[1] |=> ext_ref_sample == $past(ref_sync[0]);
    endproperty
    a_ext_sample: assert property (p_ext_sample) else $error("external level lost");
    // Stream contract: a waiting word must not change, and overflow is sticky
    property p_out_hold;
        @(posedge clk) disable iff (rst)
            (sample_valid && !sample_ready && !flush) |=> sample_valid && $stable(sample_data);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("waiting word changed");
    property p_ovf_sticky;
        @(posedge clk) disable iff (rst) overflow |=> overflow;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared");
    c_word: cover property (@(posedge clk) disable iff (rst) push && !cfg[2]);
    c_byte: cover property (@(posedge clk) disable iff (rst) push && cfg[2]);
    c_flush: cover property (@(posedge clk) disable iff (rst) flush);
    c_ovf: cover property (@(posedge clk) disable iff (rst) $rose(overflow));
    c_sync: cover property (@(posedge clk) disable iff (rst) sync_pulse);
endmodule : ldi_port

// [sim/ldi_src_model.sv]
`timescale 1ns/1ps
module ldi_src_model (
    output logic forwarded_sample_clock,
    output logic [15:0] data_lines,
    output logic frame_indicator
);
    initial begin
        forwarded_sample_clock = 1'b0;
        data_lines = 16'h0000;
        frame_indicator = 1'b0;
    end
    // Clock edge centred in the bit so the oversampler sees settled data
    task automatic edge_put(input logic [15:0] d, input logic f);
        data_lines <= d;
        frame_indicator <= f;
        #31.25;
        forwarded_sample_clock <= ~forwarded_sample_clock;
        #31.25;
    endtask : edge_put
    // Clock stands still between bursts; stale lines no longer hold
    task automatic idle();
        data_lines <= ~data_lines;
        frame_indicator <= ~frame_indicator;
    endtask : idle
endmodule : ldi_src_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, fsc, frame, byte_mode, bus_reverse, frame_resets_fifo, ext_ref_select;
    logic internal_ref_level, reference_pin_in, sample_ready, last_fall;
    logic reference_pin_out, reference_pin_oe, ext_ref_sample, sync_pulse, sample_valid;
    logic sample_parity, overflow;
    logic [15:0] data_lines, sample_data;
    int fail_count = 0;
    int n_checks = 0;
    int n_sync = 0;
    ldi_src_model u_ldi_src_model (.forwarded_sample_clock(fsc), .data_lines(data_lines),
        .frame_indicator(frame));
    ldi_port u_ldi_port (.clk(clk), .rst(rst), .forwarded_sample_clock(fsc),
        .data_lines(data_lines), .frame_indicator(frame), .byte_mode(byte_mode),
        .bus_reverse(bus_reverse), .frame_resets_fifo(frame_resets_fifo),
        .ext_ref_select(ext_ref_select), .internal_ref_level(internal_ref_level),
        .reference_pin_in(reference_pin_in), .reference_pin_out(reference_pin_out),
        .reference_pin_oe(reference_pin_oe), .ext_ref_sample(ext_ref_sample),
        .sync_pulse(sync_pulse), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .sample_parity(sample_parity), .overflow(overflow));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (sync_pulse === 1'b1)
            n_sync++;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    // Ends on a falling edge so registered outputs are settled when read
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic send(input logic [15:0] d, input logic f);
        u_ldi_src_model.edge_put(d, f);
        if (fsc === 1'b0)
            last_fall = f;
    endtask : send
    task automatic rd(input int lim, output logic got, output logic [15:0] d, output logic p);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (sample_valid !== 1'b1 && i < lim);
        got = (sample_valid === 1'b1);
        d = sample_data;
        p = sample_parity;
        if (got) begin
            @(posedge clk) sample_ready <= 1'b1;
            @(posedge clk) sample_ready <= 1'b0;
        end
    endtask : rd
    task automatic expect_s(input logic [15:0] ed, input logic ep, input logic usep);
        logic got, p;
        logic [15:0] d;
        rd(100, got, d, p);
        if (got !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: no sample", $time);
            end_sim();
        end
        chk(d, ed);
        if (usep)
            chk_bit(p, ep);
    endtask : expect_s
    task automatic do_reset();
        @(posedge clk) rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        last_fall = 1'b0;
        cyc(5);
    endtask : do_reset
    task automatic t_ref();
        @(posedge clk) internal_ref_level <= 1'b1;
        cyc(10);
        chk_bit(reference_pin_oe, 1'b1);
        chk_bit(reference_pin_out, 1'b1);
        @(posedge clk) internal_ref_level <= 1'b0;
        cyc(10);
        chk_bit(reference_pin_out, 1'b0);
        @(posedge clk) ext_ref_select <= 1'b1;
        reference_pin_in <= 1'b1;
        cyc(10);
        chk_bit(reference_pin_oe, 1'b0);
        chk_bit(ext_ref_sample, 1'b1);
        @(posedge clk) reference_pin_in <= 1'b0;
        cyc(10);
        chk_bit(ext_ref_sample, 1'b0);
        $display("reference test done");
    endtask : t_ref
    task automatic t_word();
        logic [15:0] w[4] = '{16'h8001, 16'h4002, 16'h2004, 16'h1008};
        logic f[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        logic p[4];
        int s;
        s = n_sync;
        foreach (w[i]) begin
            send(w[i], f[i]);
            p[i] = last_fall;
        end
        u_ldi_src_model.idle();
        foreach (w[i])
            expect_s(w[i], p[i], 1'b1);
        chk(16'(n_sync - s), 16'h0001);
        $display("word test done");
    endtask : t_word
    task automatic t_rev();
        @(posedge clk) bus_reverse <= 1'b1;
        cyc(10);
        send(16'h0001, 1'b0);
        send(16'h00f0, 1'b0);
        u_ldi_src_model.idle();
        expect_s(16'h8000, 1'b0, 1'b0);
        expect_s(16'h0f00, 1'b0, 1'b0);
        @(posedge clk) bus_reverse <= 1'b0;
        $display("reverse test done");
    endtask : t_rev
    task automatic t_byte();
        @(posedge clk) byte_mode <= 1'b1;
        cyc(10);
        send(16'ha512, 1'b0);
        send(16'h5a34, 1'b0);
        send(16'hffab, 1'b0);
        send(16'h00cd, 1'b0);
        u_ldi_src_model.idle();
        expect_s(16'h1234, 1'b0, 1'b0);
        expect_s(16'habcd, 1'b0, 1'b0);
        @(posedge clk) byte_mode <= 1'b0;
        cyc(10);
        $display("byte test done");
    endtask : t_byte
    task automatic t_fill();
        for (int i = 0; i < 36; i++)
            send(16'(i) + 16'h0100, 1'b0);
        u_ldi_src_model.idle();
        cyc(10);
        chk_bit(overflow, 1'b1);
        // Output register plus 32 FIFO words survive; the last three are dropped
        for (int i = 0; i < 33; i++)
            expect_s(16'(i) + 16'h0100, 1'b0, 1'b0);
        cyc(20);
        chk_bit(sample_valid, 1'b0);
        chk_bit(overflow, 1'b1);
        $display("fill test done");
    endtask : t_fill
    task automatic t_flush();
        int s;
        @(posedge clk) frame_resets_fifo <= 1'b1;
        cyc(10);
        s = n_sync;
        for (int i = 1; i < 5; i++)
            send(16'h1111 * 16'(i), 1'b0);
        // First frame word lands on a rising link edge and flushes itself
        send(16'h7777, 1'b1);
        send(16'h7777, 1'b1);
        u_ldi_src_model.idle();
        cyc(20);
        expect_s(16'h7777, 1'b1, 1'b1);
        cyc(20);
        chk_bit(sample_valid, 1'b0);
        chk(16'(n_sync - s), 16'h0000);
        @(posedge clk) frame_resets_fifo <= 1'b0;
        $display("flush test done");
    endtask : t_flush
    initial begin
        rst = 1'b1;
        byte_mode = 1'b0;
        bus_reverse = 1'b0;
        frame_resets_fifo = 1'b0;
        ext_ref_select = 1'b0;
        internal_ref_level = 1'b0;
        reference_pin_in = 1'b0;
        sample_ready = 1'b0;
        last_fall = 1'b0;
        do_reset();
        t_ref();
        t_word();
        t_rev();
        t_byte();
        t_fill();
        t_flush();
        do_reset();
        chk_bit(overflow, 1'b0);
        end_sim();
    end
endmodule : tb_top
